// ### common/timer_pkg.sv
/*
  constants, field layouts and carrier types for one reload timer channel.
  assumes a single 10 MHz core clock and a plain strobe register port.
*/
package timer_pkg;
    localparam int addr_w = 4;
    localparam int data_w = 16;
    localparam logic [3:0] mode_off = 4'h0;
    localparam logic [3:0] count_off = 4'h4;
    localparam logic [3:0] start_off = 4'h8;
    localparam logic [3:0] gate_off = 4'hc;
    localparam logic [15:0] count_rst = 16'h0000;
    localparam logic [15:0] count_max = 16'hffff;
    localparam logic [15:0] count_one = 16'h0001;
    localparam logic [4:0] f2_mask = 5'h01;
    localparam logic [4:0] f8_mask = 5'h07;
    localparam logic [4:0] f32_mask = 5'h1f;
    localparam logic [2:0] clk_f1 = 3'h0;
    localparam logic [2:0] clk_f2 = 3'h1;
    localparam logic [2:0] clk_f8 = 3'h2;
    localparam logic [2:0] clk_f32 = 3'h3;
    localparam logic [2:0] clk_fc32 = 3'h4;
    localparam logic [1:0] src_pin = 2'h0;
    localparam logic [1:0] src_b2 = 2'h1;
    localparam logic [1:0] src_prev = 2'h2;
    localparam logic [1:0] src_next = 2'h3;
    typedef enum logic [1:0] {mode_timer, mode_event, mode_oneshot, mode_pwm} op_mode_t;
    // sel_a: timer gate enable / event falling edge; sel_b: gate high / external direction
    typedef struct packed {
        logic up_prog;
        logic [2:0] clk_sel;
        logic free_run;
        logic sel_b;
        logic sel_a;
        logic pulse_out;
        op_mode_t operating_mode_field;
    } mode_t;
    localparam mode_t mode_rst = '0;
    typedef struct packed {
        logic [addr_w-1:0] addr;
        logic [data_w-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage

// ### rtl/reload_timer_channel.sv
/*
  one 16-bit reload timer channel: timer mode and single-phase event counter mode.
  assumes pins and neighbour wrap pulses are synchronous to core_clk.
*/
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module reload_timer_channel (
    input wire logic core_clk,
    input wire logic reset,
    input wire timer_pkg::reg_req_t reg_req,
    output logic [timer_pkg::data_w-1:0] rdata,
    input wire logic timer_event_input_pin,
    input wire logic toggle_pin_in,
    input wire logic sub_clk_in,
    input wire logic b2_wrap,
    input wire logic prev_wrap,
    input wire logic next_wrap,
    output logic timer_toggle_output_pin,
    output logic toggle_pin_oe,
    output logic irq_req
);
    import timer_pkg::*;

    mode_t mode_reg;
    logic [1:0] gate_sel_reg;
    logic run_reg;
    logic ticked_reg;
    logic [15:0] count_reg;
    logic [15:0] reload_reg;
    logic [15:0] count_next;
    logic [4:0] div_reg;
    logic [4:0] sub_div_reg;
    logic [2:0] evt_sync;
    logic [1:0] dir_sync;
    logic [2:0] sub_sync;
    logic out_reg;
    logic oe_reg;
    logic irq_reg;
    logic [15:0] rdata_reg;
    logic src_pulse;
    logic gate_ok;
    logic counting;
    logic tick;
    logic count_up;
    logic wrap;
    logic ev_mode;
    logic wr_count;

    function automatic logic div_hit(input logic [4:0] cnt, input logic [4:0] mask);
        div_hit = (cnt & mask) == mask;
    endfunction

    function automatic logic wr_at(input reg_req_t r, input logic [3:0] off);
        wr_at = r.wr && (r.addr == off);
    endfunction

    assign ev_mode = mode_reg.operating_mode_field == mode_event;
    assign wr_count = wr_at(reg_req, count_off);
    // one-shot and pwm are not built here, so those modes simply hold
    assign counting = run_reg && (ev_mode || mode_reg.operating_mode_field == mode_timer);

    // first flop of each chain feeds only the second
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            evt_sync <= 3'h0;
            dir_sync <= 2'h0;
            sub_sync <= 3'h0;
        end
        else
        begin
            evt_sync <= {evt_sync[1:0], timer_event_input_pin};
            dir_sync <= {dir_sync[0], toggle_pin_in};
            sub_sync <= {sub_sync[1:0], sub_clk_in};
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            div_reg <= 5'h00;
            sub_div_reg <= 5'h00;
        end
        else
        begin
            div_reg <= div_reg + 5'h01;
            if (sub_sync[1] && !sub_sync[2])
            begin
                sub_div_reg <= sub_div_reg + 5'h01;
            end
        end
    end

    always_comb
    begin
        src_pulse = 1'b0;
        gate_ok = 1'b1;
        if (ev_mode)
        begin
            case (gate_sel_reg)
                src_pin: src_pulse = mode_reg.sel_a ? (!evt_sync[1] && evt_sync[2])
                                                    : (evt_sync[1] && !evt_sync[2]);
                src_b2: src_pulse = b2_wrap;
                src_prev: src_pulse = prev_wrap;
                src_next: src_pulse = next_wrap;
                default: src_pulse = 1'b0;
            endcase
        end
        else
        begin
            case (mode_reg.clk_sel)
                clk_f1: src_pulse = 1'b1;
                clk_f2: src_pulse = div_hit(div_reg, f2_mask);
                clk_f8: src_pulse = div_hit(div_reg, f8_mask);
                clk_f32: src_pulse = div_hit(div_reg, f32_mask);
                clk_fc32: src_pulse = sub_sync[1] && !sub_sync[2] && div_hit(sub_div_reg, f32_mask);
                default: src_pulse = 1'b0;
            endcase
            if (mode_reg.sel_a)
            begin
                gate_ok = evt_sync[1] == mode_reg.sel_b;
            end
        end
    end

    assign tick = counting && src_pulse && gate_ok;
    // external direction: low pin counts down, high counts up
    assign count_up = ev_mode && (mode_reg.sel_b ? dir_sync[1] : mode_reg.up_prog);

    always_comb
    begin
        if (count_up)
        begin
            wrap = count_reg == count_max;
            count_next = wrap ? (mode_reg.free_run ? count_rst : reload_reg) : count_reg + count_one;
        end
        else
        begin
            wrap = count_reg == count_rst;
            if (wrap)
            begin
                count_next = (ev_mode && mode_reg.free_run) ? count_max : reload_reg;
            end
            else
            begin
                count_next = count_reg - count_one;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            mode_reg <= mode_rst;
            gate_sel_reg <= src_pin;
            run_reg <= 1'b0;
        end
        else
        begin
            if (wr_at(reg_req, mode_off))
            begin
                mode_reg <= mode_t'(reg_req.wdata[$bits(mode_t)-1:0]);
            end
            if (wr_at(reg_req, gate_off))
            begin
                gate_sel_reg <= reg_req.wdata[1:0];
            end
            if (wr_at(reg_req, start_off))
            begin
                run_reg <= reg_req.wdata[0];
            end
        end
    end

    // remembers whether a source tick has arrived since start
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            ticked_reg <= 1'b0;
        end
        else if (!run_reg)
        begin
            ticked_reg <= 1'b0;
        end
        else if (tick)
        begin
            ticked_reg <= 1'b1;
        end
    end

    // whole-word writes only; bytes are not merged
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            count_reg <= count_rst;
            reload_reg <= count_rst;
        end
        else
        begin
            if (wr_count)
            begin
                reload_reg <= reg_req.wdata;
            end
            if (wr_count && !(run_reg && ticked_reg))
            begin
                count_reg <= reg_req.wdata;
            end
            else if (tick)
            begin
                count_reg <= count_next;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            irq_reg <= 1'b0;
            out_reg <= 1'b0;
            oe_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= tick && wrap;
            // the pin turns input when it carries the external direction
            oe_reg <= mode_reg.pulse_out && !(ev_mode && mode_reg.sel_b);
            if (!counting || !mode_reg.pulse_out)
            begin
                out_reg <= 1'b0;
            end
            else if (tick && wrap)
            begin
                out_reg <= !out_reg;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rdata_reg <= 16'h0000;
        end
        else if (reg_req.rd)
        begin
            case (reg_req.addr)
                mode_off: rdata_reg <= 16'(mode_reg);
                count_off: rdata_reg <= count_reg;
                start_off: rdata_reg <= {15'h0000, run_reg};
                gate_off: rdata_reg <= {14'h0000, gate_sel_reg};
                default: rdata_reg <= 16'h0000;
            endcase
        end
        else
        begin
            rdata_reg <= 16'h0000;
        end
    end

    assign rdata = rdata_reg;
    assign timer_toggle_output_pin = out_reg;
    assign toggle_pin_oe = oe_reg;
    assign irq_req = irq_reg;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    chk_timer_reload: assert property (
        (tick && !wr_count && !ev_mode && count_reg == count_rst) |=> count_reg == $past(reload_reg))
        else $error("timer did not reload on underflow");
    chk_timer_down: assert property (
        (tick && !wr_count && !ev_mode && count_reg != count_rst) |=> count_reg == $past(count_reg) - count_one)
        else $error("timer did not count down by one");
    chk_stop_hold: assert property (
        (!run_reg && !wr_count) |=> count_reg == $past(count_reg))
        else $error("counter moved while stopped");
    chk_irq_wrap: assert property (
        (tick && wrap) |=> irq_req)
        else $error("interrupt request missing after wrap");
    chk_irq_quiet: assert property (
        !(tick && wrap) |=> !irq_req)
        else $error("interrupt request without a wrap");
    chk_write_both: assert property (
        (wr_count && !ticked_reg) |=> count_reg == $past(reg_req.wdata) && reload_reg == count_reg)
        else $error("early write did not load counter");
    chk_write_reload: assert property (
        (wr_count && run_reg && ticked_reg && !tick) |=> count_reg == $past(count_reg)
            && reload_reg == $past(reg_req.wdata))
        else $error("late write touched counter");
    chk_read_count: assert property (
        (reg_req.rd && reg_req.addr == count_off) |=> rdata == $past(count_reg))
        else $error("count read returned wrong value");
    chk_gate_hold: assert property (
        (!ev_mode && mode_reg.sel_a && evt_sync[1] != mode_reg.sel_b) |-> !tick)
        else $error("gated timer still ticked");
    chk_pulse_toggle: assert property (
        (tick && wrap && counting && mode_reg.pulse_out) |=> out_reg != $past(out_reg) || !counting)
        else $error("pulse output did not toggle");
    chk_out_low: assert property (
        !counting |=> !timer_toggle_output_pin)
        else $error("pulse output not low while idle");
    chk_freerun_up: assert property (
        (tick && !wr_count && count_up && mode_reg.free_run && wrap) |=> count_reg == count_rst)
        else $error("free-run overflow did not wrap to zero");
    chk_event_up: assert property (
        (tick && !wr_count && count_up && !wrap) |=> count_reg == $past(count_reg) + count_one)
        else $error("event counter did not count up by one");
    chk_event_reload: assert property (
        (tick && !wr_count && ev_mode && !mode_reg.free_run && wrap) |=> count_reg == $past(reload_reg))
        else $error("event counter did not reload on wrap");
    chk_oe_dir: assert property (
        (ev_mode && mode_reg.sel_b) |=> !toggle_pin_oe)
        else $error("pin driven while it carries the direction input");
endmodule
`default_nettype wire

// ### sim/event_source.sv
/* far-side pulse source for the timer channel.
   assumes core_clk; drives the input pin or one wrap line. */
`timescale 1ns/1ps
`default_nettype none
module event_source (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [7:0] count,
    input wire logic [1:0] line_sel,
    output logic pin,
    output logic [2:0] wraps,
    output logic busy
);
    logic [7:0] left_reg;
    logic [2:0] phase_reg;
    assign busy = left_reg != 8'h00;
    // pin idles low like a pulled-down line, high 3 of 6 cycles
    assign pin = busy && phase_reg < 3'h3 && line_sel == 2'h0;
    // wraps are one-cycle pulses: prev/next/b2 never hold high
    assign wraps[0] = busy && phase_reg == 3'h0 && line_sel == 2'h1;
    assign wraps[1] = busy && phase_reg == 3'h0 && line_sel == 2'h2;
    assign wraps[2] = busy && phase_reg == 3'h0 && line_sel == 2'h3;
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            left_reg <= 8'h00;
        else if (start)
            left_reg <= count;
        else if (busy && phase_reg == 3'h5)
            left_reg <= left_reg - 8'h01;
    end
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            phase_reg <= 3'h0;
        else if (start || phase_reg == 3'h5)
            phase_reg <= 3'h0;
        else if (busy)
            phase_reg <= phase_reg + 3'h1;
    end
endmodule
`default_nettype wire

// ### sim/reload_timer_event_counter_bench.sv
/* self-checking bench for the reload timer channel.
   assumes event_source on the far side and one 10 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module reload_timer_event_counter_bench;
    import timer_pkg::*;
    logic core_clk = 0, reset = 1, dir = 1, sub = 0, go = 0;
    reg_req_t req = '0;
    logic [15:0] rdata, v;
    logic [7:0] num = 8'h00;
    logic [1:0] sel = 2'h0;
    logic pin, tout, oe, irq, busy;
    logic [2:0] wraps;
    int fail_count = 0, tests_run = 0, g, k;
    // shared pin: device level when it drives, else the far side
    wire logic dir_w = oe ? tout : dir;
    reload_timer_channel reload_timer_channel_inst (.core_clk(core_clk), .reset(reset), .reg_req(req),
        .rdata(rdata), .timer_event_input_pin(pin), .toggle_pin_in(dir_w), .sub_clk_in(sub),
        .b2_wrap(wraps[0]), .prev_wrap(wraps[1]), .next_wrap(wraps[2]),
        .timer_toggle_output_pin(tout), .toggle_pin_oe(oe), .irq_req(irq));
    event_source event_source_inst (.core_clk(core_clk), .reset(reset), .start(go), .count(num),
        .line_sel(sel), .pin(pin), .wraps(wraps), .busy(busy));
    initial forever #50 core_clk = ~core_clk;
    // sub clock changes on the rising edge, period of four core cycles
    initial
    begin
        forever
        begin
            repeat (2) @(posedge core_clk);
            sub <= ~sub;
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // whole 16-bit words only
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task gap(output int n);
        for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge core_clk) #1;
        @(posedge core_clk) #1;
        for (n = 1; n < 3000 && irq !== 1'b1; n++) @(posedge core_clk) #1;
    endtask
    task burst(input logic [1:0] s, input logic [7:0] n);
        k = 0;
        @(posedge core_clk);
        sel <= s;
        num <= n;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (6 * n + 12) @(posedge core_clk) #1 k += (irq === 1'b1);
    endtask
    task setup(input logic [15:0] m, input logic [1:0] s, input logic [15:0] c);
        wr(start_off, 16'h0000);
        wr(mode_off, m);
        wr(gate_off, 16'(s));
        wr(count_off, c);
    endtask
    task t_reset;
        rd(count_off, v);
        chk(v, count_rst);
        rd(4'h2, v);
        chk(v, 16'h0000);
        rd(mode_off, v);
        chk(v, 16'h0000);
        $display("reset test done");
    endtask
    task t_timer;
        logic p;
        logic [15:0] w;
        setup(16'h0004, 2'h0, 16'h0003);
        rd(count_off, v);
        chk(v, 16'h0003);
        rd(mode_off, v);
        chk(v, 16'h0004);
        wr(start_off, 16'h0001);
        gap(g);
        chk(16'(g), 16'h0004);
        chk(16'(oe), 16'h0001);
        p = tout;
        wr(count_off, 16'h0005);
        gap(g);
        gap(g);
        chk(16'(g), 16'h0006);
        chk(16'(tout), {15'h0000, ~p});
        wr(start_off, 16'h0000);
        repeat (2) @(posedge core_clk);
        chk(16'(tout), 16'h0000);
        rd(count_off, v);
        rd(count_off, w);
        chk(w, v);
        // one-shot code is not built: counter holds and the pin stays low
        setup(16'h0006, 2'h0, 16'h0005);
        wr(start_off, 16'h0001);
        repeat (4) @(posedge core_clk);
        rd(count_off, v);
        chk(v, 16'h0005);
        chk(16'(tout), 16'h0000);
        $display("timer test done");
    endtask
    task t_clk;
        logic [2:0] cs[5] = '{clk_f1, clk_f2, clk_f8, clk_f32, clk_fc32};
        int ex[5] = '{1, 2, 8, 32, 128};
        foreach (cs[i])
        begin
            setup(16'(cs[i]) << 6, 2'h0, 16'h0000);
            wr(start_off, 16'h0001);
            gap(g);
            chk(16'(g), 16'(ex[i]));
        end
        $display("clock test done");
    endtask
    task t_gate;
        setup(16'h0018, 2'h0, 16'h0000);
        wr(start_off, 16'h0001);
        burst(2'h0, 8'h00);
        chk(16'(k), 16'h0000);
        burst(2'h0, 8'h02);
        chk(16'(k), 16'h0006);
        // gate closed after ticks: write reaches reload only
        wr(count_off, 16'h0009);
        rd(count_off, v);
        chk(v, 16'h0000);
        burst(2'h0, 8'h01);
        chk(16'(k), 16'h0001);
        rd(count_off, v);
        chk(v, 16'h0007);
        $display("gate test done");
    endtask
    task t_event;
        // 0..3 rising pin and wrap lines, 4 counts up, 5 falling pin edges
        for (int s = 0; s < 6; s++)
        begin
            setup(s == 4 ? 16'h0201 : (s == 5 ? 16'h0009 : 16'h0001),
                s > 3 ? 2'h0 : 2'(s), s == 4 ? 16'hfffe : 16'h0002);
            wr(start_off, 16'h0001);
            burst(s > 3 ? 2'h0 : 2'(s), 8'h06);
            chk(16'(k), s == 4 ? 16'h0003 : 16'h0002);
        end
        for (int f = 0; f < 2; f++)
        begin
            setup(16'h0201 | 16'(f << 5), 2'h0, 16'hfffe);
            wr(start_off, 16'h0001);
            burst(2'h0, 8'h03);
            rd(count_off, v);
            chk(v, f ? 16'h0001 : 16'hffff);
        end
        $display("event test done");
    endtask
    task t_dir;
        for (int d = 0; d < 2; d++)
        begin
            @(posedge core_clk);
            dir <= d[0];
            // pulse output asked for too: the pin must still turn input
            setup(16'h0015, 2'h0, 16'h0005);
            wr(start_off, 16'h0001);
            burst(2'h0, 8'h02);
            rd(count_off, v);
            chk(v, d ? 16'h0007 : 16'h0003);
            chk(16'(oe), 16'h0000);
        end
        $display("direction test done");
    endtask
    task results;
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        t_reset;
        t_timer;
        t_clk;
        t_gate;
        t_event;
        t_dir;
        results;
    end
    // whole run is about a thousand cycles; allow far more
    initial
    begin
        #3000000;
        fail_count++;
        results;
    end
endmodule
`default_nettype wire
